// >>> bdcr_host.sv
`timescale 1ns/10ps
// ********
// host side of the register port
// ********
module bdcr_host (
   // clock
   input wire logic ref_clk_i,
   // requests
   output logic wr_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic op_o
);
   initial {wr_en_o, addr_o, wdata_o, op_o} = 18'h00000;
   // one request per edge, held up to the sampling edge
   task automatic xfer(input logic v, input logic w, input logic [7:0] a, input logic [7:0] d);
      op_o <= v;
      wr_en_o <= w;
      addr_o <= a;
      wdata_o <= v ? d : ~wdata_o;
      @(posedge ref_clk_i);
   endtask
endmodule // bdcr_host

// >>> bdcr_pkg.sv
// ***************************************************************
// types and constants
// ***************************************************************
package bdcr_pkg;
   // register addresses
   localparam logic [7:0] ADDR_CURRENT_LIMIT_CONFIG = 8'h02;
   localparam logic [7:0] ADDR_SOFT_START_TIME = 8'h03;
   localparam logic [7:0] ADDR_STARTUP_COMMUTATION_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_DRIVE_SHAPE_LEAD_LOW = 8'h05;
   localparam logic [7:0] ADDR_LEAD_ANGLE_HIGH_DUTY = 8'h06;
   localparam logic [7:0] ADDR_LEAD_ANGLE_LIMIT = 8'h07;
   localparam logic [7:0] ADDR_SIX_WINDOW_TIMING = 8'h08;
   localparam logic [7:0] ADDR_PROPORTIONAL_GAIN = 8'h09;
   localparam int NUM_REGS = 8;
   // writable bit masks, index 0 = offset 0x02
   localparam logic [63:0] WR_MASKS = 64'h77FF_1F1F_9FFF_3F3F;
   localparam logic [7:0] REG_RESET = 8'h00;
   // field positions
   localparam int ILIM_RANGE_BIT = 5;
   localparam int ILIM_CUT_DIS_BIT = 4;
   localparam int OC_SEL_LSB = 2;
   localparam int CUT_RATE_LSB = 0;
   localparam int SHAPE_BIT = 7;
   localparam int GAIN_COARSE_LSB = 4;
   localparam int GAIN_FINE_LSB = 0;
   localparam int ZC_WIDTH_LSB = 4;
   localparam int ZC_MASK_LSB = 0;
   // thresholds in units of 0.125 mV
   localparam logic [10:0] ILIM_LOW_UNITS = 11'h190;
   localparam logic [10:0] ILIM_HIGH_UNITS = 11'h320;
   localparam logic [10:0] OC_LOW_BASE_UNITS = 11'h258;
   localparam logic [10:0] OC_HIGH_BASE_UNITS = 11'h3E8;
   localparam logic [10:0] OC_STEP_UNITS = 11'h0C8;
   localparam int SOFT_START_STEPS = 16;
   // duty cut rates in units of 0.01 %
   localparam logic [8:0] CUT_RATE_0 = 9'h00A;
   localparam logic [8:0] CUT_RATE_1 = 9'h082;
   localparam logic [8:0] CUT_RATE_2 = 9'h0FA;
   localparam logic [8:0] CUT_RATE_3 = 9'h1FB;
   // time steps: 0.102 s and 1.024 ms
   localparam int SOFT_START_STEP_US = 102000;
   localparam int COMMUTATION_STEP_NS = 1024000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int COMM_STEP_CYCLES = COMMUTATION_STEP_NS / CLK_PERIOD_NS;
   localparam int SOFT_STEP_CYCLES = SOFT_START_STEP_US * 1000 / CLK_PERIOD_NS;
   // angles in units of 0.125 deg
   localparam logic [8:0] ANGLE_LSB_UNITS = 9'h00F;
   localparam logic [8:0] ZC_WIDTH_BASE = 9'h078;
   localparam logic [8:0] ZC_WIDTH_STEP = 9'h01E;
   localparam logic [8:0] ZC_WIDTH_HI_BASE = 9'h14A;
   localparam logic [2:0] GAIN_CUT_CODE = 3'h7;

   typedef struct packed {
      logic [10:0] ilim_units;
      logic [10:0] ilim_step_units;
      logic [10:0] oc_units;
      logic duty_cut_enable;
      logic [8:0] cut_rate;
      logic [5:0] soft_start_duration;
      logic [7:0] startup_commutation_time;
      logic drive_shape_select;
      logic [8:0] lead_angle_units;
      logic [8:0] zc_width_units;
      logic [8:0] zc_mask_units;
      logic [6:0] gain_coarse;
      logic [3:0] gain_fine_eighths;
   } bdcr_cfg_t;
endpackage : bdcr_pkg

// >>> bdcr_regs.sv
`timescale 1ns/10ps
module bdcr_regs (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // register port
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic wr_reject_o,
   // device state
   input wire logic standby_i,
   input wire logic main_write_lock_i,
   input wire logic [7:0] out_duty_i,
   // decoded configuration
   output bdcr_pkg::bdcr_cfg_t cfg_o,
   output logic commutation_tick_o,
   output logic soft_start_tick_o
);
   // ***************************************************************
   // register file
   // ***************************************************************
   logic [7:0] regs_q [bdcr_pkg::NUM_REGS];
   logic lock_seen_q;
   logic [7:0] idx;
   logic hit;
   logic wr_ok;

   assign idx = addr_i - bdcr_pkg::ADDR_CURRENT_LIMIT_CONFIG;
   assign hit = (addr_i >= bdcr_pkg::ADDR_CURRENT_LIMIT_CONFIG) &&
                (addr_i <= bdcr_pkg::ADDR_PROPORTIONAL_GAIN);
   assign wr_ok = hit && standby_i && !main_write_lock_i && !lock_seen_q;

   // lock is sticky: once seen, writes stay refused
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         lock_seen_q <= 1'b0;
      end else if (clk_en_i && main_write_lock_i) begin
         lock_seen_q <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < bdcr_pkg::NUM_REGS; g++) begin : g_reg
         always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
               regs_q[g] <= bdcr_pkg::REG_RESET;
            end else if (clk_en_i && wr_en_i && wr_ok && idx == 8'(g)) begin
               regs_q[g] <= wdata_i & bdcr_pkg::WR_MASKS[g*8 +: 8];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
         wr_reject_o <= 1'b0;
      end else if (clk_en_i) begin
         rdata_o <= hit ? regs_q[idx[2:0]] : 8'h00;
         wr_reject_o <= wr_en_i && !wr_ok;
      end
   end

   // ***************************************************************
   // field decode
   // ***************************************************************
   logic [7:0] r_cl, r_ss, r_sc, r_lo, r_hi, r_lim, r_six, r_pg;
   assign r_cl = regs_q[0];
   assign r_ss = regs_q[1];
   assign r_sc = regs_q[2];
   assign r_lo = regs_q[3];
   assign r_hi = regs_q[4];
   assign r_lim = regs_q[5];
   assign r_six = regs_q[6];
   assign r_pg = regs_q[7];

   logic range_hi;
   logic [1:0] oc_code, rate_code;
   logic [3:0] w_code, m_code;
   logic [2:0] c_code, f_code;
   assign range_hi = r_cl[bdcr_pkg::ILIM_RANGE_BIT];
   assign oc_code = r_cl[bdcr_pkg::OC_SEL_LSB +: 2];
   assign rate_code = r_cl[bdcr_pkg::CUT_RATE_LSB +: 2];
   assign w_code = r_six[bdcr_pkg::ZC_WIDTH_LSB +: 4];
   assign m_code = r_six[bdcr_pkg::ZC_MASK_LSB +: 4];
   assign c_code = r_pg[bdcr_pkg::GAIN_COARSE_LSB +: 3];
   assign f_code = r_pg[bdcr_pkg::GAIN_FINE_LSB +: 3];

   // lead angle: lo + (hi - lo) * duty / 256, then clamp
   logic [4:0] la_lo, la_hi, la_lim, la_int, la_eff;
   logic [13:0] la_mix;
   assign la_lo = r_lo[4:0];
   assign la_hi = r_hi[4:0];
   assign la_lim = r_lim[4:0];
   assign la_mix = 14'(la_lo) * 14'(9'h100 - 9'(out_duty_i)) +
                   14'(la_hi) * 14'(out_duty_i);
   assign la_int = la_mix[12:8];
   assign la_eff = (la_int > la_lim) ? la_lim : la_int;

   bdcr_pkg::bdcr_cfg_t cfg_d;
   always_comb begin
      cfg_d = '0;
      cfg_d.ilim_units = range_hi ? bdcr_pkg::ILIM_HIGH_UNITS
                                  : bdcr_pkg::ILIM_LOW_UNITS;
      cfg_d.ilim_step_units = cfg_d.ilim_units / 11'(bdcr_pkg::SOFT_START_STEPS);
      cfg_d.oc_units = (range_hi ? bdcr_pkg::OC_HIGH_BASE_UNITS
                                 : bdcr_pkg::OC_LOW_BASE_UNITS)
                       + 11'(oc_code) * bdcr_pkg::OC_STEP_UNITS;
      cfg_d.duty_cut_enable = !r_cl[bdcr_pkg::ILIM_CUT_DIS_BIT];
      case (rate_code)
         2'h0: cfg_d.cut_rate = bdcr_pkg::CUT_RATE_0;
         2'h1: cfg_d.cut_rate = bdcr_pkg::CUT_RATE_1;
         2'h2: cfg_d.cut_rate = bdcr_pkg::CUT_RATE_2;
         default: cfg_d.cut_rate = bdcr_pkg::CUT_RATE_3;
      endcase
      cfg_d.soft_start_duration = r_ss[5:0];
      cfg_d.startup_commutation_time = r_sc;
      cfg_d.drive_shape_select = r_lo[bdcr_pkg::SHAPE_BIT];
      cfg_d.lead_angle_units = 9'(la_eff) * bdcr_pkg::ANGLE_LSB_UNITS;
      if (w_code < 4'h8) begin
         cfg_d.zc_width_units = bdcr_pkg::ZC_WIDTH_BASE
                                + 9'(w_code) * bdcr_pkg::ZC_WIDTH_STEP;
      end else begin
         cfg_d.zc_width_units = bdcr_pkg::ZC_WIDTH_HI_BASE
                                + 9'(w_code - 4'h7) * bdcr_pkg::ANGLE_LSB_UNITS;
      end
      cfg_d.zc_mask_units = 9'(5'(m_code) + 5'h01) * bdcr_pkg::ANGLE_LSB_UNITS;
      cfg_d.gain_coarse = (c_code == bdcr_pkg::GAIN_CUT_CODE) ? 7'h00
                                                               : 7'(8'h01 << c_code);
      cfg_d.gain_fine_eighths = 4'h8 - 4'(f_code);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cfg_o <= '0;
      end else if (clk_en_i) begin
         cfg_o <= cfg_d;
      end
   end

   // ***************************************************************
   // timing ticks
   // ***************************************************************
   // commutation tick every 1.024 ms * (code+1)
   logic [16:0] comm_cnt_q;
   logic [7:0] comm_mul_q;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         comm_cnt_q <= '0;
         comm_mul_q <= '0;
         commutation_tick_o <= 1'b0;
      end else if (clk_en_i) begin
         commutation_tick_o <= 1'b0;
         if (comm_cnt_q == 17'(bdcr_pkg::COMM_STEP_CYCLES - 1)) begin
            comm_cnt_q <= '0;
            if (comm_mul_q >= r_sc) begin
               comm_mul_q <= '0;
               commutation_tick_o <= 1'b1;
            end else begin
               comm_mul_q <= comm_mul_q + 8'h01;
            end
         end else begin
            comm_cnt_q <= comm_cnt_q + 17'h00001;
         end
      end
   end

   // soft start step tick: duration (code+1)*0.102 s over 16 steps
   logic [23:0] ss_cnt_q;
   logic [5:0] ss_mul_q;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ss_cnt_q <= '0;
         ss_mul_q <= '0;
         soft_start_tick_o <= 1'b0;
      end else if (clk_en_i) begin
         soft_start_tick_o <= 1'b0;
         if (ss_cnt_q == 24'(bdcr_pkg::SOFT_STEP_CYCLES / bdcr_pkg::SOFT_START_STEPS - 1)) begin
            ss_cnt_q <= '0;
            if (ss_mul_q >= r_ss[5:0]) begin
               ss_mul_q <= '0;
               soft_start_tick_o <= 1'b1;
            end else begin
               ss_mul_q <= ss_mul_q + 6'h01;
            end
         end else begin
            ss_cnt_q <= ss_cnt_q + 24'h000001;
         end
      end
   end
endmodule // bdcr_regs

// >>> bdcr_regs_chk.sv
`timescale 1ns/10ps
// ********
// port checks
// ********
module bdcr_regs_chk (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // watched ports
   input wire logic clk_en_i,
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic standby_i,
   input wire logic main_write_lock_i,
   input wire logic wr_reject_o,
   input wire bdcr_pkg::bdcr_cfg_t cfg_o
);
   logic seen_q;
   logic tk;
   logic bad;
   assign tk = wr_en_i & clk_en_i;
   assign bad = addr_i < 8'h02 || addr_i > 8'h09 || !standby_i || main_write_lock_i || seen_q;
   always_ff @(posedge ref_clk_i) seen_q <= !sys_rst_i && (seen_q || main_write_lock_i);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_refuse; tk && bad |=> wr_reject_o; endproperty
   a_refuse: assert property (p_refuse) else $error("write not refused");
   property p_accept; tk && !bad |=> !wr_reject_o; endproperty
   a_accept: assert property (p_accept) else $error("write refused");
   property p_cause; wr_reject_o |-> $past(tk); endproperty
   a_cause: assert property (p_cause) else $error("stray refusal");
   property p_step; cfg_o.ilim_units == cfg_o.ilim_step_units * 11'h010; endproperty
   a_step: assert property (p_step) else $error("step size");
   property p_oc;
      cfg_o.ilim_units == 11'h320 |-> cfg_o.oc_units inside {11'h3E8, 11'h4B0, 11'h578, 11'h640};
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent range");
   property p_cut; cfg_o.cut_rate inside {9'h000, 9'h00A, 9'h082, 9'h0FA, 9'h1FB}; endproperty
   a_cut: assert property (p_cut) else $error("cut rate");
   property p_gain; $onehot0(cfg_o.gain_coarse) && cfg_o.gain_fine_eighths <= 4'h8; endproperty
   a_gain: assert property (p_gain) else $error("gain");
   property p_mask; cfg_o.zc_mask_units % 9'h00F == 9'h000; endproperty
   a_mask: assert property (p_mask) else $error("mask step");
   c_rej: cover property (wr_reject_o);
   c_ok: cover property (tk && !bad);
   c_hi: cover property (cfg_o.ilim_units == 11'h320);
endmodule // bdcr_regs_chk
bind bdcr_regs bdcr_regs_chk u_chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .wr_en_i, .addr_i,
   .standby_i, .main_write_lock_i, .wr_reject_o, .cfg_o);

// >>> bldc_drive_config_registers_tb.sv
`timescale 1ns/10ps
// ********
// bench
// ********
module bldc_drive_config_registers_tb;
   logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, standby_i = 1'b1;
   logic main_write_lock_i = 1'b0, pend = 1'b0, locked = 1'b0;
   logic wr_en, op, wr_reject_o, comm_tick, ss_tick;
   int d = 0, mix = 0, ticks = 0;
   logic [7:0] addr, wdata, rdata_o, out_duty_i = 8'h00;
   logic [7:0] shadow [2:9] = '{default: 8'h00};
   logic [7:0] v [2:9];
   logic [17:0] notes [$];
   bdcr_pkg::bdcr_cfg_t cfg_o;
   int miscompares = 0, checked = 0, seed = 25;
   int rates [4] = '{10, 130, 250, 507};
   always #5 ref_clk_i = ~ref_clk_i;
   bdcr_host u_host (.ref_clk_i, .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata), .op_o(op));
   bdcr_regs dut (.ref_clk_i, .sys_rst_i, .clk_en_i(1'b1), .wr_en_i(wr_en), .addr_i(addr),
      .wdata_i(wdata), .rdata_o, .wr_reject_o, .standby_i, .main_write_lock_i, .out_duty_i,
      .cfg_o, .commutation_tick_o(comm_tick), .soft_start_tick_o(ss_tick));
   task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // notes the expected answer, then issues the request
   task automatic acc(input logic w, input logic sb, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      ok = a >= 8'h02 && a <= 8'h09;
      if (!w) notes.push_back({9'h1FF, 1'b0, ok ? shadow[a] : 8'h00});
      ok = ok && sb && !locked;
      if (w && ok) shadow[a] = d & bdcr_pkg::WR_MASKS[(a - 8'h02) * 8 +: 8];
      if (w) notes.push_back({9'h100, !ok, 8'h00});
      standby_i <= sb;
      u_host.xfer(1'b1, w, a, d);
   endtask
   always @(posedge ref_clk_i) begin
      if (comm_tick === 1'b1 || ss_tick === 1'b1) ticks++;
      if (pend) begin
         chk("port", {wr_reject_o, rdata_o} & notes[0][17:9], notes[0][8:0]);
         void'(notes.pop_front());
      end
      pend <= op;
   end
   initial begin
      repeat (12) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      for (int a = 0; a < 12; a++) acc(1'b0, 1'b1, 8'(a), 8'h00);
      for (int i = 0; i < 200; i++) acc({$random(seed)} % 3 != 0, {$random(seed)} % 4 != 0,
         8'({$random(seed)} % 12), 8'($random(seed)));
      for (int a = 0; a < 12; a++) acc(1'b0, 1'b1, 8'(a), 8'h00);
      for (int c = 0; c < 64; c++) begin
         d = {$random(seed)} % 256;
         out_duty_i <= 8'(d);
         mix = (c[4:0] * (256 - d) + (31 - c[4:0]) * d) / 256;
         v = '{8'(c), 8'(c), 8'(c * 4 + 3), {c[0], 2'b00, c[4:0]}, {3'b000, ~c[4:0]},
            {3'b000, c[5:1]}, {c[3:0], c[3:0]}, {1'b0, c[2:0], 1'b0, c[2:0]}};
         for (int a = 2; a < 10; a++) acc(1'b1, 1'b1, 8'(a), v[a]);
         u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
         u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
         chk("ilim", cfg_o.ilim_units, c[5] ? 16'h0320 : 16'h0190);
         chk("oc", cfg_o.oc_units, 16'((c[5] ? 1000 : 600) + 200 * c[3:2]));
         chk("cut_on", cfg_o.duty_cut_enable, !c[4]);
         chk("rate", cfg_o.cut_rate, 16'(rates[c[1:0]]));
         chk("sst", cfg_o.soft_start_duration, 16'(c));
         chk("comm", cfg_o.startup_commutation_time, 16'(v[4]));
         chk("shape", cfg_o.drive_shape_select, c[0]);
         chk("lead", cfg_o.lead_angle_units,
            16'(15 * (mix < c[5:1] ? mix : c[5:1])));
         chk("width", cfg_o.zc_width_units,
            16'(c[3] ? 330 + 15 * (c[3:0] - 7) : 120 + 30 * c[3:0]));
         chk("mask", cfg_o.zc_mask_units, 16'(15 * (c[3:0] + 1)));
         chk("coarse", cfg_o.gain_coarse, 16'(c[2:0] == 7 ? 0 : 1 << c[2:0]));
         chk("fine", cfg_o.gain_fine_eighths, 16'(8 - c[2:0]));
      end
      // lock in the same cycle as a write, then stays after release
      locked = 1'b1;
      main_write_lock_i <= 1'b1;
      acc(1'b1, 1'b1, 8'h03, 8'h15);
      main_write_lock_i <= 1'b0;
      acc(1'b1, 1'b1, 8'h09, 8'h11);
      acc(1'b0, 1'b1, 8'h09, 8'h00);
      u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
      u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
      chk("left", 16'(notes.size()), 16'h0000);
      chk("ticks", 16'(ticks), 16'h0000);
      test_done();
   end
endmodule // bldc_drive_config_registers_tb
